// [design/tsr_map.svh]
// Purpose: constants of the temperature sensor readout block
// Assumes: included by bare name from the package and the design modules
// Notes: definitions only
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

`define TSR_WORD_W 16
`define TSR_TEMP_W 13
`define TSR_CNT_W 7
`define TSR_OSC_CNT_W 16
`define TSR_FRAME_EDGES 7'h40
`define TSR_TEMP_LSB_POS 3
`define TSR_DONE_POS 2
`define TSR_LAST_DRIVEN_POS 4'h2
`define TSR_SHUTDOWN_CODE 8'hff
// arbitrary identification value, not tied to any real part
`define TSR_ID_CODE 8'h3c
`define TSR_ID_LOW_BITS 6'h00
`define TSR_UNDRIVEN_BITS 2'h3
`define TSR_CLK_HZ 250000000
`define TSR_OSC_HZ 30000
`define TSR_CONV_MS 300
`define TSR_OSC_DIV_CYC (`TSR_CLK_HZ / `TSR_OSC_HZ)
`define TSR_CONV_OSC_TICKS ((`TSR_OSC_HZ * `TSR_CONV_MS) / 1000)

`endif

// [design/tsr_pkg.sv]
// Purpose: types and gray helpers shared by the readout modules
// Assumes: tsr_map.svh holds every numeric constant
// Notes: gray coding carries edge counts from the link clock to clk_sys
`include "tsr_map.svh"

package tsr_pkg;

    typedef logic [`TSR_CNT_W-1:0] tsr_cnt_t;
    typedef logic [`TSR_WORD_W-1:0] tsr_word_t;
    typedef logic [`TSR_TEMP_W-1:0] tsr_temp_t;

    typedef enum logic [0:0] {TSR_CONV_RUN, TSR_CONV_HALT} tsr_conv_e;
    typedef enum logic [0:0] {TSR_FRAME_IDLE, TSR_FRAME_ACTIVE} tsr_frame_e;

    function automatic tsr_cnt_t tsr_bin2gray(input tsr_cnt_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic tsr_cnt_t tsr_gray2bin(input tsr_cnt_t g);
        tsr_cnt_t b;
        b = '0;
        for (int i = `TSR_CNT_W - 1; i >= 0; i--) begin
            b[i] = (i == `TSR_CNT_W - 1) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction

endpackage

// [design/tsr_link.sv]
// Purpose: serial-clock side of the readout link: edge counters and config shifter
// Assumes: sck may toggle outside frames; cs_n high clears every counter at once
// Notes: counts leave as gray code so clk_sys can sample them safely
`timescale 1ns/1ns
`include "tsr_map.svh"

module tsr_link
    import tsr_pkg::*;
(
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sio_i,
    output tsr_cnt_t fall_gray,
    output tsr_cnt_t rise_gray,
    output tsr_word_t cfg_shift
);

    // one state word per edge of sck, since the two edges are separate clocks here
    typedef struct packed {
        tsr_cnt_t cnt;
        tsr_cnt_t gray;
    } tsr_fall_s;

    typedef struct packed {
        tsr_cnt_t cnt;
        tsr_cnt_t gray;
        tsr_word_t shift;
    } tsr_rise_s;

    tsr_fall_s f_q;
    tsr_fall_s f_d;
    tsr_rise_s r_q;
    tsr_rise_s r_d;

    always_comb begin
        f_d = f_q;
        if (f_q.cnt != `TSR_FRAME_EDGES) begin
            f_d.cnt = f_q.cnt + 7'h01;
        end
        f_d.gray = tsr_bin2gray(f_d.cnt);
    end

    always_comb begin
        r_d = r_q;
        if (r_q.cnt != `TSR_FRAME_EDGES) begin
            r_d.cnt = r_q.cnt + 7'h01;
            if (r_q.cnt[4]) begin
                r_d.shift = {r_q.shift[`TSR_WORD_W-2:0], sio_i};
            end
        end
        r_d.gray = tsr_bin2gray(r_d.cnt);
    end

    // select high holds both counters cleared, so sck is ignored outside frames
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign fall_gray = f_q.gray;
    assign rise_gray = r_q.gray;
    assign cfg_shift = r_q.shift;

endmodule

// [design/tsr_top.sv]
// Purpose: digital temperature sensor readout, conversion pacing and mode control
// Assumes: clk_sys at 250 MHz; sck at most 7 MHz, so many clk_sys cycles per bit
// Notes: the data pin is driven from clk_sys flip-flops that follow the link counters
//
// Notes on behaviour
// - temperature is 13-bit two's complement, 1/16 degree
// - two lowest read bits are left undriven
// - bit two shows first conversion done
// - power-up starts continuous conversion, first result later
// - supply loss resets; recovery resumes continuous mode
// - select low frames each transaction
// - serial clock ignored while select high
// - first bit at select fall, rest on falling edges
// - data line released after fourteen bits
// - select may rise early; transfer aborts cleanly
// - conversion in progress finishes despite select
// - sixteen clocks read, sixteen clocks write configuration
// - low byte all ones selects shutdown
// - identification readable only in shutdown
// - identification code sits in upper byte
// - result refreshes each conversion period while continuous
// - conversions paced by internal oscillator, not sck
// - identification bits seven to two read zero
// - serial clock up to seven megahertz, may stop
`timescale 1ns/1ns
`include "tsr_map.svh"

module tsr_top
    import tsr_pkg::*;
#(
    parameter int unsigned OSC_DIV_CYC = `TSR_OSC_DIV_CYC,
    parameter int unsigned CONV_OSC_TICKS = `TSR_CONV_OSC_TICKS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic power_ok,
    input wire logic [`TSR_TEMP_W-1:0] temp_sense,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sio_i,
    output logic sio_o,
    output logic sio_oe,
    output logic mode_shutdown,
    output logic first_conv_done
);

    localparam logic [`TSR_OSC_CNT_W-1:0] OSC_LAST = `TSR_OSC_CNT_W'(OSC_DIV_CYC - 1);
    localparam logic [`TSR_OSC_CNT_W-1:0] CONV_LAST = `TSR_OSC_CNT_W'(CONV_OSC_TICKS - 1);
    localparam tsr_word_t ID_WORD = {`TSR_ID_CODE, `TSR_ID_LOW_BITS, `TSR_UNDRIVEN_BITS};

    typedef struct packed {
        // synchronisers: stage one feeds stage two only
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        tsr_cnt_t fall_s1;
        tsr_cnt_t fall_s2;
        tsr_cnt_t rise_s1;
        tsr_cnt_t rise_s2;
        logic pwr_s1;
        logic pwr_s2;
        tsr_temp_t temp_s1;
        tsr_temp_t temp_s2;
        // conversion engine
        tsr_conv_e conv;
        logic [`TSR_OSC_CNT_W-1:0] osc_cnt;
        logic [`TSR_OSC_CNT_W-1:0] conv_cnt;
        tsr_temp_t result;
        logic done;
        logic shutdown;
        // frame handling
        tsr_frame_e frame;
        tsr_word_t snap;
        tsr_cnt_t cfg_seen;
        logic sio;
        logic oe;
    } tsr_sys_s;

    localparam tsr_sys_s SYS_RST = '{
        cs_s1: 1'b1,
        cs_s2: 1'b1,
        cs_prev: 1'b1,
        fall_s1: '0,
        fall_s2: '0,
        rise_s1: '0,
        rise_s2: '0,
        pwr_s1: 1'b0,
        pwr_s2: 1'b0,
        temp_s1: '0,
        temp_s2: '0,
        conv: TSR_CONV_RUN,
        osc_cnt: '0,
        conv_cnt: '0,
        result: '0,
        done: 1'b0,
        shutdown: 1'b0,
        frame: TSR_FRAME_IDLE,
        snap: '0,
        cfg_seen: '0,
        sio: 1'b0,
        oe: 1'b0
    };

    tsr_sys_s q;
    tsr_sys_s d;

    tsr_cnt_t fall_gray;
    tsr_cnt_t rise_gray;
    tsr_word_t cfg_shift;

    tsr_link u_link (
        .sck(sck),
        .cs_n(cs_n),
        .sio_i(sio_i),
        .fall_gray(fall_gray),
        .rise_gray(rise_gray),
        .cfg_shift(cfg_shift)
    );

    tsr_cnt_t fall_bin;
    tsr_cnt_t rise_bin;
    logic osc_tick;
    logic frame_start;
    logic cs_low;
    logic cfg_ready;
    logic read_phase;
    logic [3:0] bit_idx;
    tsr_word_t out_word;

    always_comb begin
        d = q;

        // two flip-flops on everything that comes from pins or the sck domain except cfg_shift, which is sampled directly
        d.cs_s1 = cs_n;
        d.cs_s2 = q.cs_s1;
        d.cs_prev = q.cs_s2;
        d.fall_s1 = fall_gray;
        d.fall_s2 = q.fall_s1;
        d.rise_s1 = rise_gray;
        d.rise_s2 = q.rise_s1;
        d.pwr_s1 = power_ok;
        d.pwr_s2 = q.pwr_s1;
        d.temp_s1 = temp_sense;
        d.temp_s2 = q.temp_s1;

        fall_bin = tsr_gray2bin(q.fall_s2);
        rise_bin = tsr_gray2bin(q.rise_s2);
        cs_low = !q.cs_s2;
        frame_start = q.cs_prev && !q.cs_s2;

        // internal oscillator model: divided from clk_sys, never from sck
        osc_tick = (q.osc_cnt == OSC_LAST);
        if (osc_tick) begin
            d.osc_cnt = '0;
        end else begin
            d.osc_cnt = q.osc_cnt + `TSR_OSC_CNT_W'(1);
        end

        // conversion runs regardless of select; a started one always completes
        unique case (q.conv)
            TSR_CONV_RUN: begin
                if (osc_tick) begin
                    if (q.conv_cnt == CONV_LAST) begin
                        d.conv_cnt = '0;
                        d.result = q.temp_s2;
                        d.done = 1'b1;
                        if (q.shutdown) begin
                            d.conv = TSR_CONV_HALT;
                        end
                    end else begin
                        d.conv_cnt = q.conv_cnt + `TSR_OSC_CNT_W'(1);
                    end
                end
            end
            TSR_CONV_HALT: begin
                d.conv_cnt = '0;
                if (!q.shutdown) begin
                    d.conv = TSR_CONV_RUN;
                end
            end
        endcase

        // frame tracking follows the synchronised select
        unique case (q.frame)
            TSR_FRAME_IDLE: begin
                if (frame_start) begin
                    d.frame = TSR_FRAME_ACTIVE;
                    // snapshot keeps the word steady even if a conversion lands now
                    d.snap = {q.result, q.done, `TSR_UNDRIVEN_BITS};
                    d.cfg_seen = '0;
                end
            end
            TSR_FRAME_ACTIVE: begin
                if (!cs_low) begin
                    d.frame = TSR_FRAME_IDLE;
                end
            end
        endcase

        // a full 16-bit write completes at rising edge 32 or 64
        cfg_ready = (q.frame == TSR_FRAME_ACTIVE) && cs_low && (rise_bin[4:0] == 5'h00)
            && (rise_bin != '0) && (rise_bin != q.cfg_seen);
        if (cfg_ready) begin
            d.cfg_seen = rise_bin;
            d.shutdown = (cfg_shift[7:0] == `TSR_SHUTDOWN_CODE);
        end

        // reading: falling-edge count picks the bit, second read word is the id in shutdown
        read_phase = !fall_bin[4] && (fall_bin < `TSR_FRAME_EDGES);
        bit_idx = 4'hf - fall_bin[3:0];
        if (fall_bin[5] && q.shutdown) begin
            out_word = ID_WORD;
        end else begin
            out_word = q.snap;
        end
        if ((q.frame == TSR_FRAME_ACTIVE) && cs_low && read_phase
            && (bit_idx >= `TSR_LAST_DRIVEN_POS)) begin
            d.oe = 1'b1;
            d.sio = out_word[bit_idx];
        end else begin
            // low two bits and everything after bit two float; pull-up reads high
            d.oe = 1'b0;
            d.sio = 1'b0;
        end

        // supply below threshold behaves as a reset of the functional state
        if (!q.pwr_s2) begin
            d.conv = TSR_CONV_RUN;
            d.osc_cnt = '0;
            d.conv_cnt = '0;
            d.result = '0;
            d.done = 1'b0;
            d.shutdown = 1'b0;
            d.frame = TSR_FRAME_IDLE;
            d.oe = 1'b0;
            d.sio = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q <= SYS_RST;
        end else begin
            q <= d;
        end
    end

    assign sio_o = q.sio;
    assign sio_oe = q.oe;
    assign mode_shutdown = q.shutdown;
    assign first_conv_done = q.done;

endmodule

// [testbench/tsr_top_properties.sv]
// Purpose: port checker for tsr_top
// Assumes: sck phases span several clk_sys cycles
// Notes: sck edge counts rebuilt here, cleared by cs_n
`timescale 1ns/1ns
module tsr_top_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic power_ok,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sio_o,
    input wire logic sio_oe,
    input wire logic mode_shutdown,
    input wire logic first_conv_done
);
    logic [6:0] rise_q;
    logic [6:0] fall_q;
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) rise_q <= 7'h00;
        else rise_q <= rise_q + 7'h01;
    end
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) fall_q <= 7'h00;
        else fall_q <= fall_q + 7'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n || !power_ok);
    sequence s_read; (!cs_n && fall_q < 7'h0d) [*6]; endsequence
    sequence s_write; (!cs_n && fall_q > 7'h0d && fall_q < 7'h20) [*6]; endsequence
    sequence s_loss; $fell(power_ok) ##1 !power_ok [*5]; endsequence
    a_idle_quiet: assert property (cs_n [*6] |-> !sio_oe)
        else $error("pin driven while idle");
    a_read_drive: assert property (s_read |-> sio_oe)
        else $error("pin not driven in read");
    a_write_quiet: assert property (s_write |-> !sio_oe)
        else $error("pin driven after bit two");
    a_abort_release: assert property ($rose(cs_n) |-> ##[1:5] !sio_oe)
        else $error("pin held after select rose");
    a_bit_hold: assert property ((sck && !cs_n && sio_oe) [*5] |-> $stable(sio_o))
        else $error("bit moved while sck high");
    a_done_sticky: assert property (first_conv_done |=> first_conv_done)
        else $error("done flag dropped");
    a_mode_write: assert property ($changed(mode_shutdown) |-> rise_q == 7'h20 || rise_q == 7'h40)
        else $error("mode moved outside a write");
    a_supply_reset: assert property (disable iff (!reset_n) s_loss |-> !first_conv_done && !mode_shutdown)
        else $error("supply loss kept state");
endmodule

bind tsr_top tsr_top_properties u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .power_ok(power_ok), .sck(sck), .cs_n(cs_n),
    .sio_o(sio_o), .sio_oe(sio_oe), .mode_shutdown(mode_shutdown), .first_conv_done(first_conv_done)
);

// [testbench/tsr_host_model.sv]
// Purpose: serial bus master model
// Assumes: lclk is the free running link base clock
// Notes: every change lands just after an lclk edge
`timescale 1ns/1ns
module tsr_host_model
    import tsr_pkg::*;
(
    input wire logic lclk,
    input wire logic sio,
    output logic sck,
    output logic cs_n,
    output logic drv_en,
    output logic drv_bit
);
    int gap = 2;
    // one early select rise clears the link counters, which have no other reset
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
        #1;
        cs_n = 1'b1;
    end
    task automatic half();
        repeat (gap) @(posedge lclk);
    endtask
    // pulses 1-16 read, 17-32 write, 33-48 read, 49-64 write; fewer cuts it short
    task automatic frame(input int pulses, input logic [31:0] cfg, output tsr_word_t rd_a, output tsr_word_t rd_b);
        rd_a = '1;
        rd_b = '1;
        half();
        cs_n = 1'b0;
        half();
        half();
        for (int k = 0; k < pulses; k++) begin
            drv_en = k[4];
            drv_bit = cfg[(k < 32 ? 47 - k : 63 - k) & 31];
            half();
            if (k < 16) rd_a[15 - k] = sio;
            else if (k >= 32 && k < 48) rd_b[47 - k] = sio;
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
        half();
        drv_en = 1'b0;
        cs_n = 1'b1;
        half();
    endtask
    task automatic wiggle(input int n);
        repeat (n) begin
            half();
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for the readout
// Assumes: short conversion pacing, pull-up on data line
// Notes: corner and seeded random temperatures
`timescale 1ns/1ns
`include "tsr_map.svh"
`define TB_CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module testbench
    import tsr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic lclk = 1'b0;
    logic reset_n, power_ok, sck, cs_n, sio, sio_o, sio_oe, mode_shutdown, first_conv_done, drv_en, drv_bit;
    tsr_temp_t temp_sense, t;
    tsr_word_t rd_a, rd_b;
    logic [7:0] code;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 32'hcc8e;
    tsr_temp_t corner [4] = '{13'h0fff, 13'h1000, 13'h0000, 13'h1fff};
    // released line floats high on the pull-up
    assign sio = sio_oe ? sio_o : (drv_en ? drv_bit : 1'b1);
    always #2 clk_sys = ~clk_sys;
    initial begin
        #1;
        forever #6 lclk = ~lclk;
    end
    tsr_top #(.OSC_DIV_CYC(4), .CONV_OSC_TICKS(3)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .power_ok(power_ok), .temp_sense(temp_sense), .sck(sck),
        .cs_n(cs_n), .sio_i(sio), .sio_o(sio_o), .sio_oe(sio_oe), .mode_shutdown(mode_shutdown),
        .first_conv_done(first_conv_done)
    );
    tsr_host_model u_host (.lclk(lclk), .sio(sio), .sck(sck), .cs_n(cs_n), .drv_en(drv_en), .drv_bit(drv_bit));
    function automatic tsr_word_t exp_temp(input tsr_temp_t v);
        return {v, 1'b1, 2'b11};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic rd_temp(input tsr_temp_t v);
        cyc(1);
        temp_sense = v;
        cyc(60);
        u_host.frame(16, 32'h0, rd_a, rd_b);
        `TB_CHECK(rd_a, exp_temp(v));
    endtask
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        power_ok = 1'b1;
        temp_sense = 13'h0000;
        cyc(6);
        reset_n = 1'b1;
        cyc(2);
        `TB_CHECK({sio_oe, mode_shutdown, first_conv_done}, 3'b000);
        cyc(60);
        `TB_CHECK(first_conv_done, 1'b1);
        for (int i = 0; i < 8; i++) begin
            t = (i < 4) ? corner[i] : tsr_temp_t'($random(seed));
            if (i == 5) u_host.wiggle(8);
            rd_temp(t);
        end
        rd_temp(13'h0123);
        u_host.gap = 3;
        fork
            u_host.frame(16, 32'h0, rd_a, rd_b);
            begin
                cyc(40);
                temp_sense = 13'h1abc;
            end
        join
        u_host.gap = 2;
        `TB_CHECK(rd_a, exp_temp(13'h0123));
        rd_temp(t);
        u_host.frame(4, 32'h0, rd_a, rd_b);
        `TB_CHECK(rd_a[15:12], t[12:9]);
        for (int i = 0; i < 9; i++) begin
            code = 8'hff >> (8 - i);
            u_host.frame(32, {8'($random(seed)), code, 16'h0}, rd_a, rd_b);
            cyc(4);
            `TB_CHECK(mode_shutdown, code == 8'hff);
        end
        cyc(1);
        temp_sense = 13'h0555;
        cyc(80);
        u_host.frame(24, 32'h0, rd_a, rd_b);
        `TB_CHECK({mode_shutdown, rd_a}, {1'b1, exp_temp(t)});
        u_host.frame(64, 32'h5aff_0000, rd_a, rd_b);
        `TB_CHECK(rd_b, {`TSR_ID_CODE, 8'h03});
        cyc(4);
        `TB_CHECK(mode_shutdown, 1'b0);
        cyc(80);
        u_host.frame(48, 32'h0, rd_a, rd_b);
        `TB_CHECK(rd_b, exp_temp(13'h0555));
        u_host.frame(32, 32'h00ff_0000, rd_a, rd_b);
        cyc(1);
        power_ok = 1'b0;
        cyc(20);
        `TB_CHECK({mode_shutdown, first_conv_done}, 2'b00);
        power_ok = 1'b1;
        cyc(80);
        `TB_CHECK({mode_shutdown, first_conv_done}, 2'b01);
        end_sim();
    end
endmodule
